// file: rtl/cif_flag_cell.sv
`timescale 1ns/1ps
module cif_flag_cell (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);

  cif_pkg::cif_cell_t st_r;
  cif_pkg::cif_cell_t st_nxt;

  // ----------------------------------------------------------------
  // Sticky flag, cleared by a write of one
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Set is checked last so an event is never lost to a clear
    if (clear_in) begin
      st_nxt.flag = 1'b0;
    end
    if (set_in) begin
      st_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= cif_pkg::CELL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_out = st_r.flag;

endmodule

// file: rtl/cif_interrupt_flags.sv
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
// Contract
// - An overload frame sent while error active or passive sets bit 15.
// - The transmit error count reaching 256 or more sets bit 14.
// - Either error count reaching 128 or more sets bit 13.
// - The receive error count reaching 96 or more sets bit 12.
// - The transmit error count reaching 96 or more sets bit 11.
// - A remote frame received in an unmasked mailbox sets bit 10.
// - Bit 10 is read-only and clears only when all remote pending bits are clear.
// - A data or remote frame received in an unmasked mailbox sets bit 9.
// - Bit 9 is read-only and clears only when all receive pending bits are clear.
// - The flag word is 16 bits and bits 15 to 9 are zero after reset.
// - Bits 15 to 11 clear on a write of one and keep their value on a write of zero.
module cif_interrupt_flags (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic irq_out,
  input wire logic overload_sent_in,
  input wire logic [1:0] fault_state_in,
  input wire logic [8:0] transmit_error_count_in,
  input wire logic [8:0] receive_error_count_in,
  input wire logic [15:0] rx_complete_in,
  input wire logic [15:0] remote_rx_complete_in,
  input wire logic [15:0] mailbox_interrupt_mask_in,
  input wire logic [15:0] receive_complete_pending_in,
  input wire logic [15:0] remote_request_pending_in,
  output logic [15:0] can_interrupt_flags_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cif_pkg::cif_state_t st_r;
  cif_pkg::cif_state_t st_nxt;
  logic [4:0] w1c_flag;
  logic [4:0] w1c_set;
  logic [4:0] w1c_clr;
  logic [3:0] above_now;
  logic remote_set;
  logic rx_set;
  logic [6:0] set_vec;
  logic [6:0] irq_clr;
  logic [15:0] flags;
  logic req;
  logic acc_wr;
  logic wr_flags;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    return addr == off;
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake: one wait state per access
  // ----------------------------------------------------------------
  assign req = read_in | write_in;
  assign waitrequest_out = req & ~st_r.ack;
  assign acc_wr = write_in & st_r.ack;
  assign wr_flags = acc_wr & hit(address_in, cif_pkg::OFF_FLAGS) & byteenable_in[1];

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Threshold flags fire on crossing, so a clear is not undone at once
  // while the counter stays high
  assign above_now[3] = transmit_error_count_in >= cif_pkg::BUS_OFF_LIMIT;
  assign above_now[2] = (transmit_error_count_in >= cif_pkg::PASSIVE_LIMIT) ||
                        (receive_error_count_in >= cif_pkg::PASSIVE_LIMIT);
  assign above_now[1] = receive_error_count_in >= cif_pkg::WARNING_LIMIT;
  assign above_now[0] = transmit_error_count_in >= cif_pkg::WARNING_LIMIT;

  assign w1c_set[4] = overload_sent_in & (fault_state_in != cif_pkg::CIF_BUS_OFF);
  assign w1c_set[3:0] = above_now & ~st_r.above;
  assign remote_set = |(remote_rx_complete_in & ~mailbox_interrupt_mask_in);
  assign rx_set = |(rx_complete_in & ~mailbox_interrupt_mask_in);
  assign set_vec = {w1c_set, remote_set, rx_set};

  assign w1c_clr = wr_flags ? writedata_in[15:11] : 5'h00;
  assign irq_clr = (acc_wr & hit(address_in, cif_pkg::OFF_IRQ_CLEAR) & byteenable_in[1]) ?
                   writedata_in[15:9] : 7'h00;

  // ----------------------------------------------------------------
  // Write-one-to-clear flags
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < cif_pkg::NUM_W1C; g++) begin : g_cell
      cif_flag_cell u_cell (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .set_in(w1c_set[g]),
        .clear_in(w1c_clr[g]),
        .flag_out(w1c_flag[g])
      );
    end
  endgenerate

  assign flags = {w1c_flag, st_r.remote_flag, st_r.rx_msg_flag, 9'h000};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.above = above_now;
    // Summary flags follow the pending words; a new set wins because the
    // pending word only shows the new bit one cycle later
    if (remote_set) begin
      st_nxt.remote_flag = 1'b1;
    end else if (remote_request_pending_in == 16'h0000) begin
      st_nxt.remote_flag = 1'b0;
    end
    if (rx_set) begin
      st_nxt.rx_msg_flag = 1'b1;
    end else if (receive_complete_pending_in == 16'h0000) begin
      st_nxt.rx_msg_flag = 1'b0;
    end
    st_nxt.irq_status = set_vec | (st_r.irq_status & ~irq_clr);
    if (acc_wr && hit(address_in, cif_pkg::OFF_IRQ_ENABLE) && byteenable_in[1]) begin
      st_nxt.irq_enable = writedata_in[15:9];
    end
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      unique case (address_in)
        cif_pkg::OFF_FLAGS: st_nxt.rdata = {16'h0000, flags};
        cif_pkg::OFF_IRQ_STATUS: st_nxt.rdata = {16'h0000, st_r.irq_status, 9'h000};
        cif_pkg::OFF_IRQ_ENABLE: st_nxt.rdata = {16'h0000, st_r.irq_enable, 9'h000};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= cif_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign readdata_out = st_r.rdata;
  assign irq_out = |(st_r.irq_status & st_r.irq_enable);
  assign can_interrupt_flags_out = flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // Flag set checks
  // ----------------------------------------------------------------
  // Thresholds are checked on the crossing; a level check would fight the clear
  a_overload_set: assert property (
    (overload_sent_in && fault_state_in != cif_pkg::CIF_BUS_OFF) |=> flags[15])
    else $error("overload flag not set");

  a_overload_bus_off: assert property (
    (overload_sent_in && fault_state_in == cif_pkg::CIF_BUS_OFF && !flags[15]) |=>
    !flags[15])
    else $error("overload flag set while bus off");

  a_bus_off_set: assert property (
    $rose(transmit_error_count_in >= cif_pkg::BUS_OFF_LIMIT) |=> flags[14])
    else $error("bus off flag not set");

  a_passive_set: assert property (
    $rose((transmit_error_count_in >= cif_pkg::PASSIVE_LIMIT) ||
    (receive_error_count_in >= cif_pkg::PASSIVE_LIMIT)) |=> flags[13])
    else $error("error passive flag not set");

  a_rx_warn_set: assert property (
    $rose(receive_error_count_in >= cif_pkg::WARNING_LIMIT) |=> flags[12])
    else $error("rx warning flag not set");

  a_tx_warn_set: assert property (
    $rose(transmit_error_count_in >= cif_pkg::WARNING_LIMIT) |=> flags[11])
    else $error("tx warning flag not set");

  // ----------------------------------------------------------------
  // Summary flag checks
  // ----------------------------------------------------------------
  a_remote_set: assert property (
    |(remote_rx_complete_in & ~mailbox_interrupt_mask_in) |=> flags[10] ##1 flags[10] ||
    remote_request_pending_in == 16'h0000)
    else $error("remote summary flag not set");

  a_remote_hold: assert property (
    (flags[10] && remote_request_pending_in != 16'h0000) |=> flags[10])
    else $error("remote summary dropped early");

  a_remote_drop: assert property (
    (flags[10] && remote_request_pending_in == 16'h0000 &&
    (remote_rx_complete_in & ~mailbox_interrupt_mask_in) == 16'h0000) |=> !flags[10])
    else $error("remote summary flag stuck");

  a_rx_msg_set: assert property (
    |(rx_complete_in & ~mailbox_interrupt_mask_in) |=> flags[9])
    else $error("receive summary flag not set");

  a_masked_quiet: assert property (
    (!flags[9] && (rx_complete_in & ~mailbox_interrupt_mask_in) == 16'h0000) |=>
    !flags[9])
    else $error("masked mailbox set the summary");

  a_rx_msg_hold: assert property (
    (flags[9] && receive_complete_pending_in != 16'h0000) |=> flags[9])
    else $error("receive summary dropped early");

  a_rx_msg_drop: assert property (
    (flags[9] && receive_complete_pending_in == 16'h0000 && !rx_set) |=> !flags[9])
    else $error("receive summary flag stuck");

  // ----------------------------------------------------------------
  // Clearing checks
  // ----------------------------------------------------------------
  a_reset_zero: assert property (disable iff (1'b0)
    rst_in |=> (flags == 16'h0000 && readdata_out == 32'h0000_0000))
    else $error("flags not zero after reset");

  a_write_zero_keep: assert property (
    (wr_flags && !writedata_in[14] && flags[14]) |=> flags[14])
    else $error("write of zero cleared a flag");

  a_keep_overload: assert property (
    (wr_flags && !writedata_in[15] && flags[15]) |=> flags[15])
    else $error("write of zero cleared the overload flag");

  a_keep_passive: assert property (
    (wr_flags && !writedata_in[13] && flags[13]) |=> flags[13])
    else $error("write of zero cleared the passive flag");

  a_keep_rx_warn: assert property (
    (wr_flags && !writedata_in[12] && flags[12]) |=> flags[12])
    else $error("write of zero cleared the rx warning flag");

  a_keep_tx_warn: assert property (
    (wr_flags && !writedata_in[11] && flags[11]) |=> flags[11])
    else $error("write of zero cleared the tx warning flag");

  a_lane_ignored: assert property (
    (write_in && !waitrequest_out && address_in == cif_pkg::OFF_FLAGS &&
    !byteenable_in[1] && flags[15]) |=> flags[15])
    else $error("write without lane one cleared a flag");

  a_write_one_clear: assert property (
    (wr_flags && writedata_in[13] && !w1c_set[2]) |=> !flags[13])
    else $error("write of one did not clear");

  a_clear_overload: assert property (
    (wr_flags && writedata_in[15] && !w1c_set[4]) |=> !flags[15])
    else $error("write of one did not clear the overload flag");

  a_clear_bus_off: assert property (
    (wr_flags && writedata_in[14] && !w1c_set[3]) |=> !flags[14])
    else $error("write of one did not clear the bus off flag");

  a_clear_rx_warn: assert property (
    (wr_flags && writedata_in[12] && !w1c_set[1]) |=> !flags[12])
    else $error("write of one did not clear the rx warning flag");

  a_clear_tx_warn: assert property (
    (wr_flags && writedata_in[11] && !w1c_set[0]) |=> !flags[11])
    else $error("write of one did not clear the tx warning flag");

  a_set_beats_clear: assert property (
    (w1c_clr[3] && w1c_set[3]) |=> flags[14])
    else $error("clear won over set");

  // ----------------------------------------------------------------
  // Bus and interrupt checks
  // ----------------------------------------------------------------
  // Read data is captured in the wait cycle, so it shows the flags of that edge
  a_one_wait: assert property (
    (req && !st_r.ack) |=> !waitrequest_out ##1 1'b1)
    else $error("access not answered after one wait");

  a_first_wait: assert property (
    $rose(req) |-> waitrequest_out)
    else $error("access answered without a wait");

  a_idle_no_wait: assert property (
    !req |-> !waitrequest_out)
    else $error("wait shown with no access");

  a_read_flags: assert property (
    (read_in && waitrequest_out && address_in == cif_pkg::OFF_FLAGS) |=>
    readdata_out == {16'h0000, $past(flags)})
    else $error("flag read returned the wrong word");

  a_upper_zero: assert property (
    readdata_out[31:16] == 16'h0000)
    else $error("upper read half not zero");

  a_rdata_hold: assert property (
    !req |=> $stable(readdata_out))
    else $error("read data changed with no access");

  a_enable_write: assert property (
    (write_in && !waitrequest_out && address_in == cif_pkg::OFF_IRQ_ENABLE &&
    byteenable_in[1]) |=> st_r.irq_enable == $past(writedata_in[15:9]))
    else $error("enable write not taken");

  a_irq_status_set: assert property (
    (overload_sent_in && fault_state_in != cif_pkg::CIF_BUS_OFF) |=> st_r.irq_status[6])
    else $error("overload status bit not set");

  a_irq_summary_set: assert property (
    ((rx_complete_in & ~mailbox_interrupt_mask_in) != 16'h0000) |=> st_r.irq_status[0])
    else $error("receive status bit not set");

  a_irq_clear: assert property (
    (write_in && !waitrequest_out && address_in == cif_pkg::OFF_IRQ_CLEAR &&
    byteenable_in[1] && writedata_in[15] && !overload_sent_in) |=> !st_r.irq_status[6])
    else $error("status bit not cleared");

  a_irq_sticky: assert property (
    (st_r.irq_status[6] && !(write_in && address_in == cif_pkg::OFF_IRQ_CLEAR)) |=>
    st_r.irq_status[6])
    else $error("status bit dropped by itself");

  a_irq_quiet: assert property (
    (st_r.irq_enable == 7'h00) |-> !irq_out)
    else $error("interrupt raised with all bits disabled");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  c_flag_clear: cover property (wr_flags && writedata_in[15] ##1 !flags[15]);
  c_rx_summary: cover property (rx_set ##1 flags[9] ##[1:20] !flags[9]);
  c_irq_rise: cover property ($rose(irq_out));
  c_set_and_clear: cover property (w1c_clr[0] && w1c_set[0]);
  c_bus_off_flag: cover property ($rose(flags[14]));

endmodule

// file: rtl/cif_pkg.sv
package cif_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'h8;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'hC;

  // ----------------------------------------------------------------
  // Field layout of the flag word
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_W = 16;
  localparam int unsigned BIT_OVERLOAD = 15;
  localparam int unsigned BIT_BUS_OFF = 14;
  localparam int unsigned BIT_ERR_PASSIVE = 13;
  localparam int unsigned BIT_RX_WARNING = 12;
  localparam int unsigned BIT_TX_WARNING = 11;
  localparam int unsigned BIT_REMOTE = 10;
  localparam int unsigned BIT_RX_MSG = 9;
  localparam int unsigned NUM_EVENTS = 7;
  localparam int unsigned NUM_W1C = 5;

  // ----------------------------------------------------------------
  // Error counter thresholds (counters are 9 bits wide)
  // ----------------------------------------------------------------
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] WARNING_LIMIT = 9'h060;

  // ----------------------------------------------------------------
  // Types and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CIF_ERR_ACTIVE = 2'h0,
    CIF_ERR_PASSIVE = 2'h1,
    CIF_BUS_OFF = 2'h3
  } cif_fault_state_t;

  typedef struct packed {
    logic flag;
  } cif_cell_t;

  typedef struct packed {
    logic [3:0] above;
    logic remote_flag;
    logic rx_msg_flag;
    logic [6:0] irq_status;
    logic [6:0] irq_enable;
    logic ack;
    logic [31:0] rdata;
  } cif_state_t;

  localparam cif_cell_t CELL_RESET = '{flag: 1'b0};
  localparam cif_state_t STATE_RESET = '0;

endpackage

// file: test/cif_node_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side node: error counts, frame pulses, pending words
// ----------------------------------------
module cif_node_model (
  input wire logic clock_in,
  output logic ov_out,
  output logic [1:0] fs_out,
  output logic [8:0] tec_out,
  output logic [8:0] rec_out,
  output logic [15:0] rx_out,
  output logic [15:0] rf_out,
  output logic [15:0] rxp_out,
  output logic [15:0] rfp_out
);
  initial begin
    {ov_out, fs_out, tec_out, rec_out, rx_out, rf_out, rxp_out, rfp_out} = '0;
  end
  // Pulses last one cycle; a remote frame also counts as a received frame
  task automatic frame(input logic ov, input logic [15:0] rx, input logic [15:0] rf);
    @(posedge clock_in);
    ov_out <= ov;
    rx_out <= rx | rf;
    rf_out <= rf;
    @(posedge clock_in);
    {ov_out, rx_out, rf_out} <= '0;
    rxp_out <= rxp_out | rx | rf;
    rfp_out <= rfp_out | rf;
  endtask
  // Pending bits drop only where software cleared them
  task automatic levels(input logic [1:0] fs, input logic [8:0] t, input logic [8:0] r,
    input logic [15:0] crx, input logic [15:0] crf);
    @(posedge clock_in);
    fs_out <= fs;
    tec_out <= t;
    rec_out <= r;
    rxp_out <= rxp_out & ~crx;
    rfp_out <= rfp_out & ~crf;
  endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock_in = 0, rst_in = 1, read_in = 0, write_in = 0, waitrequest_out, irq_out, ov;
  logic [3:0] address_in = 4'h0, be = 4'hF;
  logic [31:0] writedata_in = 32'h0, readdata_out, q, seed = 32'h0000EE97;
  logic [1:0] fs;
  logic [8:0] transmit_error_count, receive_error_count, t, r;
  logic [15:0] rx, rf, mask = 16'hFFFE, rxp, rfp, flags;
  logic [8:0] cor [6] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};
  logic [1:0] fsl [3] = '{2'h0, 2'h1, 2'h3};
  int failures = 0, check_count = 0;
  cif_interrupt_flags i_dut (.clock_in(clock_in), .rst_in(rst_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .byteenable_in(be), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .irq_out(irq_out),
    .overload_sent_in(ov), .fault_state_in(fs), .transmit_error_count_in(transmit_error_count),
    .receive_error_count_in(receive_error_count), .rx_complete_in(rx), .remote_rx_complete_in(rf),
    .mailbox_interrupt_mask_in(mask), .receive_complete_pending_in(rxp),
    .remote_request_pending_in(rfp), .can_interrupt_flags_out(flags));
  cif_node_model i_node (.clock_in(clock_in), .ov_out(ov), .fs_out(fs), .tec_out(transmit_error_count),
    .rec_out(receive_error_count), .rx_out(rx), .rf_out(rf), .rxp_out(rxp), .rfp_out(rfp));
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] thr(input logic [8:0] t, input logic [8:0] r);
    return {1'b0, t >= 9'h100, t >= 9'h080 || r >= 9'h080, r >= 9'h060, t >= 9'h060, 11'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
    end
  endtask
  // Request stands until waitrequest is seen low at a rising edge; data is taken there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    read_in <= !wr;
    write_in <= wr;
    address_in <= a;
    writedata_in <= d;
    do begin
      @(posedge clock_in);
    end while (waitrequest_out);
    q = readdata_out;
    read_in <= 0;
    write_in <= 0;
  endtask
  task automatic print_verdict();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 0;
    @(negedge clock_in);
    check(flags, 0, "reset flags");
    bus(0, 4'h0, 0);
    check(q, 0, "reset read");
    for (int i = 0; i < 20; i++) begin
      t = 9'(rnd() % 400);
      r = 9'(rnd() % 400);
      if (i < 12) begin
        t = i < 6 ? cor[i] : 9'h000;
        r = i < 6 ? 9'h000 : cor[i - 6];
      end
      i_node.levels(2'h0, t, r, 16'h0, 16'h0);
      bus(0, 4'h0, 0);
      check(q, thr(t, r), "threshold");
      bus(1, 4'h0, 0);
      be <= 4'h1;
      bus(1, 4'h0, 32'h0000F800);
      be <= 4'hF;
      bus(0, 4'h0, 0);
      check(q, thr(t, r), "write zero");
      bus(1, 4'h0, 32'h0000F800);
      bus(0, 4'h0, 0);
      check(q, 0, "write one");
      i_node.levels(2'h0, 9'h0, 9'h0, 16'h0, 16'h0);
    end
    foreach (fsl[k]) begin
      i_node.levels(fsl[k], 9'h0, 9'h0, 16'h0, 16'h0);
      i_node.frame(1, 0, 0);
      bus(0, 4'h0, 0);
      check(q[15], fsl[k] != 2'h3, "overload");
      bus(1, 4'h0, 32'h00008000);
    end
    i_node.levels(2'h0, 9'h0, 9'h0, 16'h0, 16'h0);
    fork
      bus(1, 4'h0, 32'h00008000);
      begin
        @(posedge clock_in);
        i_node.frame(1, 0, 0);
      end
    join
    bus(0, 4'h0, 0);
    check(q[15], 1, "set beats clear");
    i_node.frame(0, 16'h0002, 0);
    bus(0, 4'h0, 0);
    check(q[10:9], 0, "masked mailbox");
    i_node.frame(0, 0, 16'h0001);
    bus(0, 4'h0, 0);
    check(q[10:9], 2'h3, "remote frame");
    bus(1, 4'h0, 32'h00000600);
    i_node.levels(2'h0, 9'h0, 9'h0, 16'h0001, 16'h0001);
    bus(0, 4'h0, 0);
    check(q[10:9], 2'h1, "partial pending");
    i_node.levels(2'h0, 9'h0, 9'h0, 16'hFFFF, 16'hFFFF);
    bus(0, 4'h0, 0);
    check(q[10:9], 0, "pending empty");
    mask <= 16'hFFFD;
    i_node.frame(0, 16'h0002, 0);
    bus(0, 4'h0, 0);
    check(q[10:9], 2'h1, "unmasked mailbox");
    i_node.levels(2'h0, 9'h0, 9'h0, 16'hFFFF, 16'hFFFF);
    bus(0, 4'h0, 0);
    check(q[10:9], 0, "pending cleared");
    // Interrupt: enable, clear leftovers, raise, mask, clear
    bus(1, 4'hC, 32'h0000FE00);
    bus(0, 4'hC, 0);
    check(q, 32'h0000FE00, "enable");
    bus(1, 4'h8, 32'h0000FE00);
    bus(0, 4'h4, 0);
    check(q, 0, "status cleared");
    i_node.frame(1, 0, 0);
    repeat (2) @(negedge clock_in);
    check(irq_out, 1, "irq raised");
    bus(0, 4'h4, 0);
    check(q, 32'h00008000, "status");
    bus(1, 4'hC, 0);
    repeat (2) @(negedge clock_in);
    check(irq_out, 0, "irq masked");
    bus(1, 4'h8, 32'h00008000);
    bus(0, 4'h4, 0);
    check(q, 0, "status clear");
    bus(0, 4'h8, 0);
    check(q, 0, "clear reads zero");
    bus(0, 4'h2, 0);
    check(q, 0, "unmapped");
    // Mid-run reset with the overload flag still standing
    @(negedge clock_in);
    check(flags[15], 1, "flag before reset");
    @(posedge clock_in);
    rst_in <= 1;
    repeat (2) @(posedge clock_in);
    rst_in <= 0;
    @(negedge clock_in);
    check(flags, 0, "mid reset flags");
    bus(0, 4'h0, 0);
    check(q, 0, "mid reset read");
    print_verdict();
  end
endmodule
